// ==== ascc_top.sv ====
// Async serial channel with control register A, Wishbone slave and interrupt
// Behaviour
// - Receiver runs while rx_on is one
// - Clearing rx_on aborts frame, flags held
// - rx_on forced zero in reset, io halt
// - Transmitter runs while tx_on is one
// - Clearing tx_on aborts frame, tx_empty held
// - tx_on forced zero in reset, io halt
// - request_to_send_ch0 pin follows its bit one clock later
// - Bit 3 reads last received marker bit
// - Writing zero to bit 3 clears errors
// - Bits 2..0 select length, parity, stops
// - Wake filter passes only marker-one frames
// - Without wake filter every frame updates flags
// - Wake filter ignored outside multiprocessor format
// - clk_pin_off routes shared pin to dma_end_out
// - Control A reads zero after reset
// - Multiprocessor frame: data, marker, no parity
// - Overrun when frame completes while full
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
module ascc_top (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Wishbone slave
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    input  wire logic       wb_we_i,
    input  wire logic [5:0] wb_adr_i,
    input  wire logic [3:0] wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic            wb_ack_o,
    // System state and DMA
    input  wire logic       io_halt_state,
    input  wire logic       dma_end_req,
    // Serial line
    input  wire logic       rxd_i,
    output logic            txd_o,
    output logic            request_to_send_ch0,
    // Shared channel-1 clock / DMA end pin
    input  wire logic       ch1_pin_i,
    output logic            ch1_pin_o,
    output logic            ch1_pin_oe,
    // Interrupt
    output logic            irq_o
);
    ascc_pkg::ascc_ctrl_a_t ctrl_a_ff;
    ascc_pkg::ascc_err_t    err_ff;
    ascc_pkg::ascc_state_t  rx_st_ff, tx_st_ff;
    logic [7:0]  ctrl_b_ff, rx_data_ff, rx_sh_ff, tx_data_ff, tx_sh_ff;
    logic        rx_full_ff, tx_empty_ff, marker_ff, rts_bit_ff;
    logic [2:0]  irq_st_ff, irq_msk_ff;
    logic [15:0] rx_cnt_ff, tx_cnt_ff;
    logic [3:0]  rx_bit_ff, tx_bit_ff;
    logic        rx_par_ff, rx_mark_ff, rx_fe_ff, tx_par_ff;
    logic        rxd_m_ff, rxd_s_ff, pin_m_ff, pin_s_ff;
    logic        req, wr, rd, mp, frame_done, accept, efr_clr, tx_load;
    logic [3:0]  idx;
    logic [3:0]  n_data;
    logic        rx_tick, tx_tick;

    // Byte lane 0 carries every register
    function automatic logic hit(input logic [3:0] i);
        hit = req && (idx == i);
    endfunction : hit

    assign idx     = wb_adr_i[5:2];
    assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr      = req && wb_we_i && wb_sel_i[0];
    assign rd      = req && !wb_we_i;
    assign mp      = ctrl_b_ff[ascc_pkg::CB_MP_FMT];
    assign n_data  = ctrl_a_ff.word_len ? 4'h8 : 4'h7;
    assign efr_clr = wr && hit(ascc_pkg::IDX_CTRL_A) && !wb_dat_i[ascc_pkg::CA_MARKER];
    assign rx_tick = (rx_cnt_ff == 16'h0000);
    assign tx_tick = (tx_cnt_ff == 16'h0000);
    assign tx_load = ctrl_a_ff.tx_on && (tx_st_ff == ascc_pkg::S_IDLE) && !tx_empty_ff;
    // Stop bit sampled and frame complete; a disable in the same cycle drops it
    assign frame_done = (rx_st_ff == ascc_pkg::S_STOP) && rx_tick && ctrl_a_ff.rx_on
                        && (rx_bit_ff >= {3'h0, ctrl_a_ff.stop_len});
    // Wake filter only acts in multiprocessor format
    assign accept = frame_done && !(mp && ctrl_a_ff.wake_en && !rx_mark_ff);

    // Input synchronisers
    always_ff @(posedge clk) begin
        rxd_m_ff <= rxd_i;
        rxd_s_ff <= rxd_m_ff;
        pin_m_ff <= ch1_pin_i;
        pin_s_ff <= pin_m_ff;
    end

    // Wishbone handshake, answer one cycle after the request
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    // Read data mux
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd) begin
            wb_dat_o <= 32'h0000_0000;
            case (idx)
                ascc_pkg::IDX_CTRL_A:  wb_dat_o[7:0] <= {ctrl_a_ff[7:4], marker_ff, ctrl_a_ff[2:0]};
                ascc_pkg::IDX_CTRL_B:  wb_dat_o[7:0] <= ctrl_b_ff;
                ascc_pkg::IDX_STATUS:  wb_dat_o[7:0] <= {rx_full_ff, err_ff, 2'b00, tx_empty_ff, 1'b0};
                ascc_pkg::IDX_RX_DATA: wb_dat_o[7:0] <= rx_data_ff;
                ascc_pkg::IDX_IRQ_ST:  wb_dat_o[2:0] <= irq_st_ff;
                ascc_pkg::IDX_IRQ_MSK: wb_dat_o[2:0] <= irq_msk_ff;
                ascc_pkg::IDX_MISC:    wb_dat_o[1:0] <= {pin_s_ff, rts_bit_ff};
                default:               wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Control A; enables dropped by io halt
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_a_ff <= ascc_pkg::CTRL_A_RST;
        end else begin
            if (wr && hit(ascc_pkg::IDX_CTRL_A)) begin
                ctrl_a_ff <= wb_dat_i[7:0];
            end
            if (io_halt_state) begin
                ctrl_a_ff.rx_on <= 1'b0;
                ctrl_a_ff.tx_on <= 1'b0;
            end
        end
    end

    // Control B, misc and mask registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_b_ff  <= ascc_pkg::CTRL_B_RST;
            rts_bit_ff <= ascc_pkg::RTS_RST;
            irq_msk_ff <= ascc_pkg::IRQ_RST;
        end else begin
            if (wr && hit(ascc_pkg::IDX_CTRL_B)) begin
                ctrl_b_ff <= wb_dat_i[7:0];
            end
            if (wr && hit(ascc_pkg::IDX_MISC)) begin
                rts_bit_ff <= wb_dat_i[ascc_pkg::MI_RTS];
            end
            if (wr && hit(ascc_pkg::IDX_IRQ_MSK)) begin
                irq_msk_ff <= wb_dat_i[2:0];
            end
        end
    end

    // Pins: rts and shared pin, registered outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            request_to_send_ch0 <= ascc_pkg::RTS_RST;
            ch1_pin_o           <= 1'b0;
            ch1_pin_oe          <= 1'b0;
        end else begin
            request_to_send_ch0 <= rts_bit_ff;
            // Shared pin driven with dma_end_req only while clk_pin_off is set
            ch1_pin_o  <= ctrl_a_ff.clk_pin_off && dma_end_req;
            ch1_pin_oe <= ctrl_a_ff.clk_pin_off;
        end
    end

    // Receiver: half-bit check of start, then centre sampling
    always_ff @(posedge clk) begin
        if (rst || !ctrl_a_ff.rx_on) begin
            rx_st_ff  <= ascc_pkg::S_IDLE;
            rx_cnt_ff <= 16'h0000;
            rx_bit_ff <= 4'h0;
            rx_sh_ff  <= 8'h00;
            rx_par_ff <= 1'b0;
            rx_mark_ff <= 1'b0;
            rx_fe_ff  <= 1'b0;
        end else begin
            rx_cnt_ff <= rx_tick ? 16'(ascc_pkg::BIT_CYC - 1) : rx_cnt_ff - 16'h0001;
            case (rx_st_ff)
                ascc_pkg::S_IDLE: begin
                    if (!rxd_s_ff) begin
                        rx_st_ff  <= ascc_pkg::S_START;
                        rx_cnt_ff <= 16'(ascc_pkg::HALF_CYC - 1);
                    end
                end
                ascc_pkg::S_START: begin
                    if (rx_tick) begin
                        rx_st_ff  <= rxd_s_ff ? ascc_pkg::S_IDLE : ascc_pkg::S_DATA;
                        rx_bit_ff <= 4'h0;
                        rx_sh_ff  <= 8'h00;
                        rx_par_ff <= 1'b0;
                        rx_fe_ff  <= 1'b0;
                    end
                end
                ascc_pkg::S_DATA: begin
                    if (rx_tick) begin
                        rx_sh_ff[rx_bit_ff[2:0]] <= rxd_s_ff;
                        rx_par_ff <= rx_par_ff ^ rxd_s_ff;
                        rx_bit_ff <= rx_bit_ff + 4'h1;
                        if (rx_bit_ff == n_data - 4'h1) begin
                            rx_bit_ff <= 4'h0;
                            rx_st_ff  <= mp ? ascc_pkg::S_MARK
                                       : (ctrl_a_ff.parity ? ascc_pkg::S_PAR : ascc_pkg::S_STOP);
                        end
                    end
                end
                ascc_pkg::S_MARK: begin
                    if (rx_tick) begin
                        rx_mark_ff <= rxd_s_ff;
                        rx_st_ff   <= ascc_pkg::S_STOP;
                    end
                end
                ascc_pkg::S_PAR: begin
                    if (rx_tick) begin
                        rx_par_ff <= rx_par_ff ^ rxd_s_ff; // Even parity, one flags error
                        rx_st_ff  <= ascc_pkg::S_STOP;
                    end
                end
                ascc_pkg::S_STOP: begin
                    if (rx_tick) begin
                        rx_fe_ff  <= rx_fe_ff || !rxd_s_ff;
                        rx_bit_ff <= rx_bit_ff + 4'h1;
                        if (frame_done) begin
                            rx_st_ff <= ascc_pkg::S_IDLE;
                        end
                    end
                end
                default: rx_st_ff <= ascc_pkg::S_IDLE;
            endcase
        end
    end

    // Receive flags; a new event beats a read or error clear in the same cycle, io halt beats a new event
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_full_ff <= 1'b0;
            err_ff     <= '0;
            rx_data_ff <= 8'h00;
            marker_ff  <= 1'b0;
        end else if (io_halt_state) begin
            rx_full_ff <= 1'b0;
            err_ff     <= '0;
        end else begin
            if (efr_clr) begin
                err_ff <= '0;
            end
            if (rd && hit(ascc_pkg::IDX_RX_DATA)) begin
                rx_full_ff <= 1'b0;
            end
            if (frame_done) begin
                marker_ff <= rx_mark_ff;
            end
            if (accept) begin
                rx_full_ff <= 1'b1;
                rx_data_ff <= ctrl_a_ff.word_len ? rx_sh_ff : {1'b0, rx_sh_ff[6:0]};
                if (rx_full_ff) begin
                    err_ff.overrun <= 1'b1;
                end
                if (rx_fe_ff || !rxd_s_ff) begin
                    err_ff.frm_err <= 1'b1;
                end
                if (!mp && ctrl_a_ff.parity && rx_par_ff) begin
                    err_ff.par_err <= 1'b1;
                end
            end
        end
    end

    // Transmit holding register and empty flag
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_data_ff  <= 8'h00;
            tx_empty_ff <= 1'b1;
        end else if (io_halt_state) begin
            tx_empty_ff <= 1'b1;
        end else if (wr && hit(ascc_pkg::IDX_TX_DATA)) begin
            tx_data_ff  <= wb_dat_i[7:0];
            tx_empty_ff <= 1'b0;
        end else if (tx_load) begin
            tx_empty_ff <= 1'b1;
        end
    end

    // Transmitter; abort leaves tx_empty as it was
    always_ff @(posedge clk) begin
        if (rst || !ctrl_a_ff.tx_on) begin
            tx_st_ff  <= ascc_pkg::S_IDLE;
            txd_o     <= 1'b1;
            tx_cnt_ff <= 16'h0000;
            tx_bit_ff <= 4'h0;
            tx_sh_ff  <= 8'h00;
            tx_par_ff <= 1'b0;
        end else begin
            tx_cnt_ff <= tx_tick ? 16'(ascc_pkg::BIT_CYC - 1) : tx_cnt_ff - 16'h0001;
            case (tx_st_ff)
                ascc_pkg::S_IDLE: begin
                    txd_o <= 1'b1;
                    if (tx_load) begin
                        tx_st_ff  <= ascc_pkg::S_START;
                        tx_sh_ff  <= tx_data_ff;
                        tx_par_ff <= 1'b0;
                        tx_bit_ff <= 4'h0;
                        tx_cnt_ff <= 16'(ascc_pkg::BIT_CYC - 1);
                        txd_o     <= 1'b0;
                    end
                end
                ascc_pkg::S_START, ascc_pkg::S_DATA: begin
                    if (tx_tick) begin
                        if (tx_bit_ff == n_data) begin
                            tx_bit_ff <= 4'h0;
                            tx_st_ff  <= mp ? ascc_pkg::S_MARK
                                       : (ctrl_a_ff.parity ? ascc_pkg::S_PAR : ascc_pkg::S_STOP);
                            txd_o     <= mp ? ctrl_b_ff[ascc_pkg::CB_MARK_TX]
                                       : (ctrl_a_ff.parity ? tx_par_ff : 1'b1);
                        end else begin
                            tx_st_ff  <= ascc_pkg::S_DATA;
                            txd_o     <= tx_sh_ff[0];
                            tx_par_ff <= tx_par_ff ^ tx_sh_ff[0];
                            tx_sh_ff  <= {1'b0, tx_sh_ff[7:1]};
                            tx_bit_ff <= tx_bit_ff + 4'h1;
                        end
                    end
                end
                ascc_pkg::S_MARK, ascc_pkg::S_PAR: begin
                    if (tx_tick) begin
                        tx_st_ff <= ascc_pkg::S_STOP;
                        txd_o    <= 1'b1;
                    end
                end
                ascc_pkg::S_STOP: begin
                    if (tx_tick) begin
                        tx_bit_ff <= tx_bit_ff + 4'h1;
                        if (tx_bit_ff >= {3'h0, ctrl_a_ff.stop_len}) begin // Format change mid-stop cannot wrap
                            tx_st_ff <= ascc_pkg::S_IDLE;
                        end
                    end
                end
                default: tx_st_ff <= ascc_pkg::S_IDLE;
            endcase
        end
    end

    // Sticky interrupt status, write one to clear, set wins
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_st_ff <= ascc_pkg::IRQ_RST;
            irq_o     <= 1'b0;
        end else begin
            if (wr && hit(ascc_pkg::IDX_IRQ_ST)) begin
                irq_st_ff <= irq_st_ff & ~wb_dat_i[2:0];
            end
            if (accept) begin
                irq_st_ff[ascc_pkg::IRQ_RX] <= 1'b1;
            end
            if (tx_load) begin
                irq_st_ff[ascc_pkg::IRQ_TX] <= 1'b1;
            end
            if (accept && (rx_full_ff || rx_fe_ff || !rxd_s_ff || (!mp && ctrl_a_ff.parity && rx_par_ff))) begin
                irq_st_ff[ascc_pkg::IRQ_ERR] <= 1'b1;
            end
            irq_o <= |(irq_st_ff & irq_msk_ff);
        end
    end

    // Checks
    AST_RX_HALT: assert property (@(posedge clk) disable iff (rst) io_halt_state |=> !ctrl_a_ff.rx_on)
        else $error("rx_on not cleared by io halt");
    AST_TX_HALT: assert property (@(posedge clk) disable iff (rst) io_halt_state |=> !ctrl_a_ff.tx_on)
        else $error("tx_on not cleared by io halt");
    AST_RX_ABORT: assert property (@(posedge clk) disable iff (rst) !ctrl_a_ff.rx_on |=> rx_st_ff == ascc_pkg::S_IDLE)
        else $error("receiver not aborted");
    AST_RX_HOLD: assert property (@(posedge clk) disable iff (rst)
        !ctrl_a_ff.rx_on && !io_halt_state && !efr_clr && !rd |=> $stable(rx_full_ff) && $stable(err_ff))
        else $error("flags changed while receiver off");
    AST_TX_ABORT: assert property (@(posedge clk) disable iff (rst)
        !ctrl_a_ff.tx_on && !io_halt_state && !wr |=> txd_o && $stable(tx_empty_ff))
        else $error("transmitter abort wrong");
    AST_RTS: assert property (@(posedge clk) disable iff (rst)
        wr && hit(ascc_pkg::IDX_MISC) |=> ##1 request_to_send_ch0 == $past(wb_dat_i[0], 2))
        else $error("rts pin late or wrong");
    AST_EFR: assert property (@(posedge clk) disable iff (rst) efr_clr && !accept |=> err_ff == '0)
        else $error("error flags not cleared");
    AST_WAKE: assert property (@(posedge clk) disable iff (rst)
        frame_done && mp && ctrl_a_ff.wake_en && !rx_mark_ff && !rd && !io_halt_state |=> $stable(rx_full_ff))
        else $error("filtered frame set flags");
    AST_OVR: assert property (@(posedge clk) disable iff (rst)
        accept && rx_full_ff && !io_halt_state |=> err_ff.overrun && rx_full_ff)
        else $error("overrun not flagged");
    AST_PIN: assert property (@(posedge clk) disable iff (rst) ctrl_a_ff.clk_pin_off |=> ch1_pin_oe)
        else $error("shared pin not routed to dma end");
endmodule : ascc_top

// ==== ascc_pkg.sv ====
// Package: constants, types and register map of the async serial control block
package ascc_pkg;
    // Timing
    localparam int CLK_HZ   = 50_000_000;
    localparam int BAUD_HZ  = 115_200;
    localparam int BIT_CYC  = CLK_HZ / BAUD_HZ;
    localparam int HALF_CYC = BIT_CYC / 2;
    // Register word indices (byte address = 4 * index)
    localparam logic [3:0] IDX_CTRL_A  = 4'h1;
    localparam logic [3:0] IDX_CTRL_B  = 4'h2;
    localparam logic [3:0] IDX_STATUS  = 4'h3;
    localparam logic [3:0] IDX_RX_DATA = 4'h4;
    localparam logic [3:0] IDX_TX_DATA = 4'h5;
    localparam logic [3:0] IDX_IRQ_ST  = 4'h6;
    localparam logic [3:0] IDX_IRQ_MSK = 4'h7;
    localparam logic [3:0] IDX_MISC    = 4'h8;
    // Control A fields
    localparam int CA_MARKER = 3;
    // Control B fields
    localparam int CB_MP_FMT = 6;
    localparam int CB_MARK_TX = 7;
    // Status fields
    localparam int ST_RX_FULL = 7;
    localparam int ST_OVERRUN = 6;
    localparam int ST_PAR_ERR = 5;
    localparam int ST_FRM_ERR = 4;
    localparam int ST_TX_EMPTY = 1;
    // Interrupt fields
    localparam int IRQ_RX  = 0;
    localparam int IRQ_TX  = 1;
    localparam int IRQ_ERR = 2;
    // Misc fields
    localparam int MI_RTS = 0;
    localparam int MI_PIN = 1;
    // Reset values
    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [7:0] CTRL_B_RST = 8'h00;
    localparam logic [2:0] IRQ_RST    = 3'h0;
    localparam logic       RTS_RST    = 1'b1;

    typedef struct packed {
        logic wake_en;
        logic rx_on;
        logic tx_on;
        logic clk_pin_off;
        logic marker_efr;
        logic word_len;
        logic parity;
        logic stop_len;
    } ascc_ctrl_a_t;

    typedef struct packed {
        logic overrun;
        logic par_err;
        logic frm_err;
    } ascc_err_t;

    typedef enum logic [5:0] {
        S_IDLE  = 6'b000001,
        S_START = 6'b000010,
        S_DATA  = 6'b000100,
        S_MARK  = 6'b001000,
        S_PAR   = 6'b010000,
        S_STOP  = 6'b100000
    } ascc_state_t;
endpackage : ascc_pkg

// ==== ascc_peer.sv ====
// Remote serial transceiver model on the far side of the line
`timescale 1ns/10ps
module ascc_peer (
    // Clock
    input  wire logic clk,
    // Serial line
    input  wire logic txd,
    output logic      rxd
);
    localparam int BIT = ascc_pkg::BIT_CYC;

    // Line rests at the marking level between frames
    initial rxd = 1'b1;

    // Start low, data LSB first, optional extra bit, stop bits high
    task automatic send(input logic [7:0] d, input int nb, input logic xen, input logic x, input int ns);
        logic q[$];
        q = {1'b0};
        for (int i = 0; i < nb; i++) q.push_back(d[i]);
        if (xen) q.push_back(x);
        repeat (ns) q.push_back(1'b1);
        foreach (q[i]) begin
            @(posedge clk);
            rxd <= q[i];
            repeat (BIT - 1) @(posedge clk);
        end
    endtask : send

    // Samples at bit centres; ok drops on a bad start or stop level
    task automatic recv(input int nb, input logic xen, input int ns, output logic [7:0] d, output logic x,
                        output logic ok);
        d = 8'h00;
        x = 1'b0;
        @(negedge txd);
        repeat (BIT / 2) @(posedge clk);
        ok = (txd === 1'b0);
        for (int i = 0; i < nb; i++) begin
            repeat (BIT) @(posedge clk);
            d[i] = txd;
        end
        if (xen) begin
            repeat (BIT) @(posedge clk);
            x = txd;
        end
        repeat (ns) begin
            repeat (BIT) @(posedge clk);
            ok = ok & (txd === 1'b1);
        end
    endtask : recv
endmodule : ascc_peer

// ==== ascc_top_tb.sv ====
// Self-checking bench for the control-A serial block
`timescale 1ns/10ps
module ascc_top_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic        halt = 1'b0;
    logic        dma = 1'b0;
    logic        rxd, txd, rts, pin_o, pin_oe, irq, ack, x, ok;
    logic [5:0]  adr = 6'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [7:0]  q, b, e, ex;
    logic [31:0] lfsr = 32'h8d3e;
    logic [7:0]  fmt [2] = '{8'h27, 8'h20};
    int          miscompares = 0;
    int          tests_run = 0;
    logic [7:0]  sent[$];

    // 50 MHz clock
    always #10 clk = ~clk;

    ascc_top ascc_top_i (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .io_halt_state(halt),
        .dma_end_req(dma), .rxd_i(rxd), .txd_o(txd), .request_to_send_ch0(rts), .ch1_pin_i(1'b1),
        .ch1_pin_o(pin_o), .ch1_pin_oe(pin_oe), .irq_o(irq));
    ascc_peer ascc_peer_i (.clk(clk), .txd(txd), .rxd(rxd));

    // Random bytes from a shift register, fixed start
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction : rnd

    // Classic single cycle; request held until ack is seen
    task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] d, output logic [7:0] r);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        r = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic chk(input string n, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d, q);
    endtask : wr

    task automatic rd(input string n, input logic [3:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00, q);
        chk(n, exp, q);
    endtask : rd

    // Sends one frame from the far side and records the byte
    task automatic frame(input logic xen, input logic x);
        b = rnd();
        sent.push_back(b);
        ascc_peer_i.send(b, 8, xen, x, 1);
    endtask : frame

    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize

    // Watchdog: the full run needs roughly 50k cycles
    initial begin
        repeat (90000) @(posedge clk);
        miscompares++;
        summarize();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd("ctrl_a", ascc_pkg::IDX_CTRL_A, 8'h00);
        rd("status", ascc_pkg::IDX_STATUS, 8'h02);
        rd("unmapped", 4'hf, 8'h00);
        wr(ascc_pkg::IDX_MISC, 8'h00);
        repeat (2) @(posedge clk);
        chk("rts pin", 8'h00, {7'h0, rts});
        wr(ascc_pkg::IDX_MISC, 8'h01);
        repeat (2) @(posedge clk);
        chk("rts pin", 8'h01, {7'h0, rts});
        rd("misc", ascc_pkg::IDX_MISC, 8'h03);
        // Receive, then overrun, clear strobe and disable with flags held
        wr(ascc_pkg::IDX_CTRL_A, 8'h44);
        frame(1'b0, 1'b0);
        rd("status", ascc_pkg::IDX_STATUS, 8'h82);
        rd("rx data", ascc_pkg::IDX_RX_DATA, sent.pop_front());
        frame(1'b0, 1'b0);
        frame(1'b0, 1'b0);
        rd("status", ascc_pkg::IDX_STATUS, 8'hc2);
        wr(ascc_pkg::IDX_CTRL_A, 8'h0c);
        rd("status", ascc_pkg::IDX_STATUS, 8'hc2);
        wr(ascc_pkg::IDX_CTRL_A, 8'h04);
        rd("status", ascc_pkg::IDX_STATUS, 8'h82);
        wb(1'b0, ascc_pkg::IDX_RX_DATA, 8'h00, q);
        sent.delete();
        frame(1'b0, 1'b0);
        rd("status", ascc_pkg::IDX_STATUS, 8'h02);
        // Multiprocessor wake filter
        sent.delete();
        wr(ascc_pkg::IDX_CTRL_B, 8'h40);
        wr(ascc_pkg::IDX_CTRL_A, 8'hc4);
        frame(1'b1, 1'b0);
        rd("status", ascc_pkg::IDX_STATUS, 8'h02);
        void'(sent.pop_front());
        frame(1'b1, 1'b1);
        rd("status", ascc_pkg::IDX_STATUS, 8'h82);
        rd("ctrl_a", ascc_pkg::IDX_CTRL_A, 8'hcc);
        rd("rx data", ascc_pkg::IDX_RX_DATA, sent.pop_front());
        wr(ascc_pkg::IDX_CTRL_A, 8'h44);
        frame(1'b1, 1'b0);
        rd("status", ascc_pkg::IDX_STATUS, 8'h82);
        rd("ctrl_a", ascc_pkg::IDX_CTRL_A, 8'h44);
        rd("rx data", ascc_pkg::IDX_RX_DATA, sent.pop_front());
        // Filter bit ignored without multiprocessor format; interrupt path
        wr(ascc_pkg::IDX_CTRL_B, 8'h00);
        wr(ascc_pkg::IDX_CTRL_A, 8'hc4);
        wr(ascc_pkg::IDX_IRQ_MSK, 8'h01);
        frame(1'b0, 1'b0);
        rd("rx data", ascc_pkg::IDX_RX_DATA, sent.pop_front());
        repeat (2) @(posedge clk);
        chk("irq", 8'h01, {7'h0, irq});
        wr(ascc_pkg::IDX_IRQ_MSK, 8'h00);
        repeat (2) @(posedge clk);
        chk("irq masked", 8'h00, {7'h0, irq});
        wr(ascc_pkg::IDX_IRQ_MSK, 8'h01);
        wr(ascc_pkg::IDX_IRQ_ST, 8'h01);
        repeat (2) @(posedge clk);
        chk("irq cleared", 8'h00, {7'h0, irq});
        // Transmit in two formats covering every control A format bit
        foreach (fmt[i]) begin
            b = rnd();
            ex = fmt[i][2] ? b : {1'b0, b[6:0]};
            wr(ascc_pkg::IDX_CTRL_A, fmt[i]);
            fork
                ascc_peer_i.recv(fmt[i][2] ? 8 : 7, fmt[i][1], fmt[i][0] ? 2 : 1, e, x, ok);
                wr(ascc_pkg::IDX_TX_DATA, b);
            join
            chk("tx data", ex, e);
            chk("tx parity", {7'h0, fmt[i][1] & ^ex}, {7'h0, x});
            chk("tx framing", 8'h01, {7'h0, ok});
        end
        // Transmit abort mid-frame keeps the empty flag
        repeat (ascc_pkg::BIT_CYC) @(posedge clk);
        wr(ascc_pkg::IDX_TX_DATA, 8'h55);
        repeat (1000) @(posedge clk);
        wr(ascc_pkg::IDX_TX_DATA, 8'haa);
        chk("txd busy", 8'h00, {7'h0, txd});
        wr(ascc_pkg::IDX_CTRL_A, 8'h00);
        repeat (2) @(posedge clk);
        chk("txd idle", 8'h01, {7'h0, txd});
        rd("status", ascc_pkg::IDX_STATUS, 8'h00);
        // Halt state clears both enables
        wr(ascc_pkg::IDX_CTRL_A, 8'h64);
        halt <= 1'b1;
        repeat (2) @(posedge clk);
        halt <= 1'b0;
        rd("ctrl_a", ascc_pkg::IDX_CTRL_A, 8'h04);
        // Shared pin routing
        dma <= 1'b1;
        wr(ascc_pkg::IDX_CTRL_A, 8'h10);
        repeat (2) @(posedge clk);
        chk("pin oe", 8'h01, {7'h0, pin_oe});
        chk("pin out", 8'h01, {7'h0, pin_o});
        wr(ascc_pkg::IDX_CTRL_A, 8'h00);
        repeat (2) @(posedge clk);
        chk("pin oe", 8'h00, {7'h0, pin_oe});
        summarize();
    end
endmodule : ascc_top_tb
